// *** rfm_pkg.sv ***
// Function
// [RULE_01] Fire squib on front plus safing sensor
// [RULE_02] Lamp on seven seconds after ignition on; code times it from reset release, ignition_on not used
// [RULE_03] Diagnose while ignition on, pause when cranking
// [RULE_04] Any detected fault lights the lamp
// [RULE_05] Lamp stays latched until code erased
// [RULE_06] Derive numeric code, keep it stored
// [RULE_07] Count lamp-on minutes, at most 9999
// [RULE_08] Scan tool reads and erases stored data
// [RULE_09] Count scan-tool erasures, at most 250
// [RULE_10] Driver inflator short 21, open 22
// [RULE_11] Passenger inflator short 24, open 25
// [RULE_12] Crank timing 33, capacitor high 31, low 32
// [RULE_13] Connector unlocked or lock switch open 34
// [RULE_14] First ignition supply feeds low 41, 42
// [RULE_15] Lamp circuit 43, lamp driver 44
// [RULE_16] Only 34, 41, 42, 43 auto erasable
// [RULE_17] Auto erase after clean 5-second interval
// [RULE_18] Last auto erase clears lamp and durations
// [RULE_19] Auto erase not counted, none while cranking
// [RULE_20] Counters saturate instead of wrapping
// [RULE_21] Ticks from prescaled clock, restart at reset
package rfm_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SEC_NS = 1_000_000_000;
  localparam int SEC_CYCLES_DEF = SEC_NS / CLK_PERIOD_NS;
  localparam int LAMP_CHECK_S = 7;
  localparam int AUTO_ERASE_S = 5;
  localparam int MINUTE_S = 60;
  localparam logic [13:0] DUR_MAX = 14'd9999;
  localparam logic [7:0] ERASE_MAX = 8'hfa;
  localparam int NSLOT = 12;
  // Slot order matches the fault input vector
  localparam logic [7:0] CODE_TABLE [NSLOT] = '{
    8'h15, 8'h16, 8'h18, 8'h19, 8'h1f, 8'h20,
    8'h21, 8'h22, 8'h29, 8'h2a, 8'h2b, 8'h2c};
  localparam logic [NSLOT-1:0] AUTO_MASK = 12'h780;
  // Register byte offsets
  localparam logic [7:0] REG_ERASE = 8'h00;
  localparam logic [7:0] REG_STORED = 8'h04;
  localparam logic [7:0] REG_DURATION = 8'h08;
  localparam logic [7:0] REG_ERASE_CNT = 8'h0c;
  localparam logic [7:0] REG_LAST_CODE = 8'h10;
  localparam logic [7:0] REG_CODE_SEL = 8'h14;
  localparam logic [7:0] REG_CODE_VAL = 8'h18;
  localparam int ERASE_BIT = 0;
  localparam int VAL_STORED_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PH_CHECK = 2'h1,
    PH_RUN = 2'h2
  } rfm_phase_t;
endpackage : rfm_pkg

// *** rfm_top.sv ***
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module rfm_top
  import rfm_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYCLES_DEF,
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ignition_on,
  input wire logic cranking,
  input wire logic front_sensor_left,
  input wire logic front_sensor_right,
  input wire logic safing_sensor,
  input wire logic drv_squib_short,
  input wire logic drv_squib_open,
  input wire logic pas_squib_short,
  input wire logic pas_squib_open,
  input wire logic cap_volt_high,
  input wire logic cap_volt_low,
  input wire logic crank_timing_fault,
  input wire logic connector_unlocked,
  input wire logic ignition_supply_one_feed_a_low,
  input wire logic ignition_supply_one_feed_b_low,
  input wire logic lamp_circuit_fault,
  input wire logic lamp_driver_fault,
  output logic squib_fire,
  output logic warning_lamp,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  // Mapped word addresses; anything else answers SLVERR
  function automatic logic addr_ok(input logic [AW-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    addr_ok = (a == AW'(b)) &&
      (b == REG_ERASE || b == REG_STORED || b == REG_DURATION ||
       b == REG_ERASE_CNT || b == REG_LAST_CODE ||
       b == REG_CODE_SEL || b == REG_CODE_VAL);
  endfunction : addr_ok
  function automatic logic [7:0] code_of(input logic [3:0] s);
    code_of = (s < 4'(NSLOT)) ? CODE_TABLE[s] : 8'h00; // [RULE_06]
  endfunction : code_of
  // Timer state
  logic [31:0] sec_cnt, next_sec_cnt;
  logic [3:0] chk_sec, next_chk_sec;
  logic [2:0] five_sec, next_five_sec;
  logic [5:0] min_sec, next_min_sec;
  rfm_phase_t phase, next_phase;
  logic sec_tick, five_tick, min_tick;
  // Fault state
  logic [NSLOT-1:0] fault_vec, stored, next_stored, clean, next_clean;
  logic [NSLOT-1:0] auto_mask;
  logic [13:0] duration, next_duration;
  logic [7:0] erase_cnt, next_erase_cnt;
  logic [7:0] last_code, next_last_code;
  logic next_lamp, next_squib, diag_en, scan_erase, erase_any;
  // Bus state
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [AW-1:0] awaddr_q, next_awaddr_q;
  logic [31:0] wdata_q, next_wdata_q;
  logic [3:0] wstrb_q, next_wstrb_q;
  logic [3:0] code_sel, next_code_sel;
  logic next_bvalid, next_rvalid, do_write;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, rd_word;
  // Prescaled second, 5 s and minute ticks; all restart at reset
  always_comb begin
    sec_tick = (sec_cnt == 32'(SEC_CYCLES - 1)); // [RULE_21]
    five_tick = sec_tick && (five_sec == 3'(AUTO_ERASE_S - 1));
    min_tick = sec_tick && (min_sec == 6'(MINUTE_S - 1));
    next_sec_cnt = sec_tick ? '0 : sec_cnt + 32'h1;
    next_five_sec = five_sec;
    next_min_sec = min_sec;
    if (sec_tick) begin
      next_five_sec = five_tick ? '0 : five_sec + 3'h1;
      next_min_sec = min_tick ? '0 : min_sec + 6'h1;
    end
    next_phase = phase;
    next_chk_sec = chk_sec;
    case (phase)
      PH_CHECK: begin
        if (sec_tick) begin
          if (chk_sec == 4'(LAMP_CHECK_S - 1)) begin
            next_phase = PH_RUN; // [RULE_02]
          end else begin
            next_chk_sec = chk_sec + 4'h1;
          end
        end
      end
      PH_RUN: begin
        next_phase = PH_RUN;
      end
      default: begin
        next_phase = PH_CHECK;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_cnt <= '0;
      chk_sec <= '0;
      five_sec <= '0;
      min_sec <= '0;
      phase <= PH_CHECK;
    end else begin
      sec_cnt <= next_sec_cnt;
      chk_sec <= next_chk_sec;
      five_sec <= next_five_sec;
      min_sec <= next_min_sec;
      phase <= next_phase;
    end
  end

  // Fault slots, codes, counters, lamp and squib
  always_comb begin
    fault_vec = {lamp_driver_fault, lamp_circuit_fault, // [RULE_15]
      ignition_supply_one_feed_b_low, // [RULE_14]
      ignition_supply_one_feed_a_low,
      connector_unlocked, crank_timing_fault, // [RULE_13] [RULE_12]
      cap_volt_low, cap_volt_high,
      pas_squib_open, pas_squib_short, // [RULE_11]
      drv_squib_open, drv_squib_short}; // [RULE_10]
    diag_en = ignition_on && !cranking; // [RULE_03]
    scan_erase = do_write && (awaddr_q == AW'(REG_ERASE)) &&
      wstrb_q[0] && wdata_q[ERASE_BIT]; // [RULE_08]
    next_clean = clean;
    auto_mask = '0;
    next_last_code = last_code;
    for (int i = 0; i < NSLOT; i++) begin
      // Auto-erasable slot is erased at the tick only if the fault stayed away all along
      if (five_tick) begin
        if (stored[i] && AUTO_MASK[i] && clean[i] && !fault_vec[i] &&
            !cranking) begin
          auto_mask[i] = 1'b1; // [RULE_16] [RULE_17] [RULE_19]
        end
        next_clean[i] = 1'b1;
      end
      if (fault_vec[i]) begin
        next_clean[i] = 1'b0;
      end
      if (diag_en && fault_vec[i] && !stored[i]) begin
        next_last_code = code_of(4'(i)); // [RULE_06]
      end
    end
    erase_any = scan_erase || (auto_mask != '0);
    next_stored = stored & ~auto_mask;
    if (scan_erase) begin
      next_stored = '0;
    end
    // A fault seen in the erase cycle still gets stored
    if (diag_en) begin
      next_stored = next_stored | fault_vec; // [RULE_04]
    end
    next_duration = duration;
    if (scan_erase || ((auto_mask != '0) && (next_stored == '0))) begin
      next_duration = '0; // [RULE_18]
    end else if (min_tick && (stored != '0) && (duration < DUR_MAX)) begin
      next_duration = duration + 14'h1; // [RULE_07] [RULE_20]
    end
    next_erase_cnt = erase_cnt;
    if (scan_erase && (erase_cnt < ERASE_MAX)) begin
      next_erase_cnt = erase_cnt + 8'h1; // [RULE_09] [RULE_20]
    end
    next_lamp = (next_phase == PH_CHECK) || (next_stored != '0) ||
      (diag_en && (fault_vec != '0)); // [RULE_05]
    next_squib = (front_sensor_left || front_sensor_right) &&
      safing_sensor; // [RULE_01]
  end
  // Nonvolatile contents modelled as flops; a real part backs them up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stored <= '0;
      clean <= '0;
      duration <= '0;
      erase_cnt <= '0;
      last_code <= '0;
      warning_lamp <= 1'b1;
      squib_fire <= 1'b0;
    end else begin
      stored <= next_stored;
      clean <= next_clean;
      duration <= next_duration;
      erase_cnt <= next_erase_cnt;
      last_code <= next_last_code;
      warning_lamp <= next_lamp;
      squib_fire <= next_squib;
    end
  end

  // AXI4-Lite slave: one write and one read at a time
  always_comb begin
    awready = !aw_held && !bvalid;
    wready = !w_held && !bvalid;
    arready = !rvalid;
    do_write = aw_held && w_held && !bvalid;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_awaddr_q = awaddr_q;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_code_sel = code_sel;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_awaddr_q = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_wdata_q = wdata;
      next_wstrb_q = wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = addr_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      if (awaddr_q == AW'(REG_CODE_SEL) && wstrb_q[0]) begin
        next_code_sel = wdata_q[3:0];
      end
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    case (8'(araddr))
      REG_STORED: rd_word = 32'(stored); // [RULE_08]
      REG_DURATION: rd_word = 32'(duration);
      REG_ERASE_CNT: rd_word = 32'(erase_cnt); // [RULE_09]
      REG_LAST_CODE: rd_word = 32'(last_code);
      REG_CODE_SEL: rd_word = 32'(code_sel);
      REG_CODE_VAL: begin
        rd_word = 32'(code_of(code_sel));
        if (code_sel < 4'(NSLOT)) begin
          rd_word[VAL_STORED_BIT] = stored[code_sel];
        end
      end
      default: rd_word = '0;
    endcase
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
      next_rdata = addr_ok(araddr) ? rd_word : '0;
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      code_sel <= '0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awaddr_q <= next_awaddr_q;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      code_sel <= next_code_sel;
    end
  end
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_crash;
    (front_sensor_left || front_sensor_right) && safing_sensor;
  endsequence
  sequence s_write_pair;
    do_write ##1 bvalid;
  endsequence
  chk_squib_fire: assert property (s_crash |=> squib_fire) // [RULE_01]
    else $error("squib did not fire on crash");
  chk_squib_cause: assert property (squib_fire |-> // [RULE_01]
    $past(front_sensor_left || front_sensor_right) && $past(safing_sensor))
    else $error("squib fired without both sensors");
  chk_lamp_check: assert property (phase == PH_CHECK |-> // [RULE_02]
    warning_lamp)
    else $error("lamp off during check");
  chk_lamp_fault: assert property (diag_en && fault_vec != '0 |=> // [RULE_04]
    warning_lamp && stored != '0)
    else $error("fault did not light lamp");
  chk_lamp_latch: assert property ($fell(warning_lamp) |-> // [RULE_05]
    $past(erase_any) || $past(phase == PH_CHECK))
    else $error("lamp dropped without erase");
  chk_crank_hold: assert property (!diag_en |=> // [RULE_03]
    (stored & ~$past(stored)) == '0)
    else $error("fault stored while diagnosis paused");
  chk_dur_sat: assert property (duration <= DUR_MAX) // [RULE_07]
    else $error("duration above maximum");
  chk_erase_count: assert property (scan_erase && erase_cnt < ERASE_MAX
    |=> erase_cnt == $past(erase_cnt) + 8'h1) // [RULE_09]
    else $error("erase count not advanced");
  chk_count_sat: assert property (erase_cnt == ERASE_MAX |=> // [RULE_20]
    erase_cnt == ERASE_MAX)
    else $error("erase count wrapped");
  chk_auto_rules: assert property (auto_mask != '0 |-> !cranking && // [RULE_19]
    (auto_mask & ~AUTO_MASK) == '0) // [RULE_16]
    else $error("illegal automatic erase");
  chk_auto_quiet: assert property (auto_mask != '0 && !scan_erase |=>
    $stable(erase_cnt)) // [RULE_19]
    else $error("automatic erase counted");
  chk_auto_clear: assert property (auto_mask != '0 && !scan_erase &&
    next_stored == '0 |=> duration == '0) // [RULE_18]
    else $error("durations kept after last erase");
  chk_write_resp: assert property (s_write_pair |-> // [RULE_08]
    bresp == (addr_ok($past(awaddr_q)) ? RESP_OKAY : RESP_SLVERR))
    else $error("write response code wrong");
endmodule : rfm_top

// *** rfm_partner.sv ***
`timescale 1ns/10ps
// Far side: crash contacts and fault sense lines, held as plain levels
module rfm_partner (
  input wire logic [2:0] sens_cmd,
  input wire logic [11:0] flt_cmd,
  output logic [2:0] contacts,
  output logic [11:0] faults
);
  // Contacts stay closed for as long as the bench commands them
  assign contacts = sens_cmd;
  assign faults = flt_cmd;
endmodule : rfm_partner

// *** rfm_top_tb.sv ***
`timescale 1ns/10ps
module rfm_top_tb;
  import rfm_pkg::*;
  localparam int SC = 20;
  localparam int LIMIT = 12000;
  logic aclk, aresetn, ign, crank, squib_fire, warning_lamp;
  logic [2:0] sens, contacts;
  logic [11:0] flt, faults;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rng;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [33:0] exq [$];
  logic [33:0] e;
  int num_errors, cmp_count, rel;
  int cyc = 0;

  rfm_partner u_far (.sens_cmd(sens), .flt_cmd(flt), .contacts(contacts),
    .faults(faults));
  rfm_top #(.SEC_CYCLES(SC)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .ignition_on(ign), .cranking(crank), .front_sensor_left(contacts[0]),
    .front_sensor_right(contacts[1]), .safing_sensor(contacts[2]),
    .drv_squib_short(faults[0]), .drv_squib_open(faults[1]),
    .pas_squib_short(faults[2]), .pas_squib_open(faults[3]),
    .cap_volt_high(faults[4]), .cap_volt_low(faults[5]),
    .crank_timing_fault(faults[6]), .connector_unlocked(faults[7]),
    .ignition_supply_one_feed_a_low(faults[8]),
    .ignition_supply_one_feed_b_low(faults[9]),
    .lamp_circuit_fault(faults[10]), .lamp_driver_fault(faults[11]),
    .squib_fire(squib_fire), .warning_lamp(warning_lamp),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  // Free-running clock, 8 ns
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // Scan tool write; ready sampled 1 ns after each edge, so no race
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic ta, tw, tb;
    exq.push_back({r, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      #1 ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end while (!tb);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic ta, tr;
    exq.push_back({r, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      #1 ta = arvalid && arready;
      tr = rvalid;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end while (!tr);
  endtask : rd

  task automatic wait_to(input int n);
    while (cyc - rel < n) @(posedge aclk);
  endtask : wait_to

  // Responses are stable at the falling edge before they are taken
  always @(negedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = exq.pop_front();
      if (bvalid && bready) chk({bresp, 32'h0}, e);
      else chk({rresp, rdata}, e);
    end
  end

  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    num_errors = 0;
    cmp_count = 0;
    rng = 32'hfe8081ff;
    {aresetn, crank, sens, flt, awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    ign = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rel = cyc;
    #1 chk({squib_fire, warning_lamp}, 34'h1);
    rd(REG_ERASE_CNT, 32'h0, RESP_OKAY);
    // Every contact combination, then random ones
    for (int i = 0; i < 16; i++) begin
      rng = xs(rng);
      @(posedge aclk);
      sens <= (i < 8) ? i[2:0] : rng[2:0];
      @(posedge aclk);
      #1 chk(squib_fire, (sens[0] | sens[1]) & sens[2]);
    end
    sens <= 3'h0;
    wait_to(110);
    #1 chk(warning_lamp, 1'b1);
    wait_to(170);
    #1 chk(warning_lamp, 1'b0);
    // Faults ignored with ignition off and while cranking
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      ign <= i[0];
      crank <= i[0];
      flt <= 12'h001;
      repeat (3) @(posedge aclk);
      flt <= 12'h000;
      ign <= 1'b1;
      crank <= 1'b0;
      rd(REG_STORED, 32'h0, RESP_OKAY);
      #1 chk(warning_lamp, 1'b0);
    end
    // All faults at once; held live so no auto erase meanwhile
    @(posedge aclk);
    flt <= 12'hfff;
    repeat (2) @(posedge aclk);
    #1 chk(warning_lamp, 1'b1);
    rd(REG_LAST_CODE, 32'h2c, RESP_OKAY);
    for (int i = 0; i < 13; i++) begin
      wr(REG_CODE_SEL, 32'(i), RESP_OKAY);
      rd(REG_CODE_VAL, (i < 12) ? {23'h0, 1'b1, CODE_TABLE[i]} : 32'h0,
         RESP_OKAY);
    end
    // Selector reads back what was last written
    rd(REG_CODE_SEL, 32'hc, RESP_OKAY);
    @(posedge aclk);
    flt <= 12'h000;
    repeat (250) @(posedge aclk);
    rd(REG_STORED, 32'h87f, RESP_OKAY);
    #1 chk(warning_lamp, 1'b1);
    wr(REG_ERASE, 32'h1, RESP_OKAY);
    rd(REG_STORED, 32'h0, RESP_OKAY);
    rd(REG_ERASE_CNT, 32'h1, RESP_OKAY);
    #1 chk(warning_lamp, 1'b0);
    // Lone auto-erasable code clears itself, not counted
    @(posedge aclk);
    flt <= 12'h100;
    @(posedge aclk);
    flt <= 12'h000;
    repeat (250) @(posedge aclk);
    rd(REG_STORED, 32'h0, RESP_OKAY);
    rd(REG_ERASE_CNT, 32'h1, RESP_OKAY);
    #1 chk(warning_lamp, 1'b0);
    // Two minute ticks with a code stored, mid-minute alignment
    while ((cyc - rel) % (60 * SC) != 600) @(posedge aclk);
    flt <= 12'h001;
    @(posedge aclk);
    flt <= 12'h000;
    repeat (2) begin
      @(posedge aclk);
      while ((cyc - rel) % (60 * SC) != 600) @(posedge aclk);
    end
    rd(REG_DURATION, 32'h2, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
    // Erase count must stop at its ceiling
    repeat (251) wr(REG_ERASE, 32'h1, RESP_OKAY);
    rd(REG_ERASE_CNT, 32'hfa, RESP_OKAY);
    rd(REG_DURATION, 32'h0, RESP_OKAY);
    give_verdict();
  end
endmodule : rfm_top_tb
